// File: shared/serial_core_defs.svh
// register offsets, field positions, reset values and counts of the serial core
`ifndef SERIAL_CORE_DEFS_SVH
`define SERIAL_CORE_DEFS_SVH
`define SC_OFF_BAUD 4'h0
`define SC_OFF_CTRL 4'h4
`define SC_OFF_STAT 4'h8
`define SC_OFF_DATA 4'hC
`define SC_ST_TXE 0
`define SC_ST_TXDONE 1
`define SC_ST_RXF 2
`define SC_ST_OVR 3
`define SC_ST_NOISE 4
`define SC_ST_FRAME 5
`define SC_ST_PARITY 6
`define SC_ST_RX9 7
`define SC_ST_PIN 8
`define SC_RST_BAUD 16'h0000
`define SC_RST_CTRL 8'h00
`define SC_SLOTS 4'hF
`define SC_FRAME8 4'hA
`define SC_FRAME9 4'hB
`define SC_BRK_EXTRA 4'h3
`define SC_STOP8 4'h9
`define SC_STOP9 4'hA
`endif

// File: shared/serial_core_pkg.sv
// types shared by the serial core
package serial_core_pkg;
	typedef struct packed {
		logic tx_ninth_bit;
		logic rx_polarity_invert;
		logic tx_polarity_invert;
		logic nine_bit_mode;
		logic long_break_select;
		logic break_send_request;
		logic rx_on;
		logic tx_on;
	} ctrl_s;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_BITS = 2'b10
	} rx_state_e;
endpackage : serial_core_pkg

// File: design/async_serial_tx_rx_core.sv
// full-duplex asynchronous serial transceiver with avalon register slave
`timescale 1ns/1ps
`include "serial_core_defs.svh"
`default_nettype none
module async_serial_tx_rx_core #(
	parameter int DIV_W = 16
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_rxd,
	output logic o_txd,
	output logic o_tx_pin_active
);
	if (DIV_W < 2 || DIV_W > 16)
	begin : g_bad_div_w
		$error("DIV_W must lie in 2..16");
	end

	// ----------------------------------------------------------------
	// register slave
	// ----------------------------------------------------------------
	logic resp_reg;
	logic req;
	logic acc;
	logic wr_ctrl;
	logic wr_baud;
	logic wr_data;
	logic rd_stat;
	logic rd_data;
	logic [DIV_W-1:0] baud_reg;
	serial_core_pkg::ctrl_s ctrl_reg;
	serial_core_pkg::ctrl_s ctrl_next;
	logic [8:0] tx_buf_reg;
	logic [8:0] rx_buf_reg;
	logic txe_reg;
	logic txdone_reg;
	logic rxf_reg;
	logic ovr_reg;
	logic noise_reg;
	logic frame_reg;
	logic arm_reg;
	logic [31:0] stat_word;

	assign req = i_avs_read | i_avs_write;
	// one wait cycle gives the registered read data time to settle
	assign o_avs_waitrequest = req & ~resp_reg;
	assign acc = req & resp_reg;
	assign wr_baud = acc & i_avs_write & (i_avs_address == `SC_OFF_BAUD);
	assign wr_ctrl = acc & i_avs_write & (i_avs_address == `SC_OFF_CTRL)
		& i_avs_byteenable[0];
	assign wr_data = acc & i_avs_write & (i_avs_address == `SC_OFF_DATA)
		& i_avs_byteenable[0];
	assign rd_stat = acc & i_avs_read & (i_avs_address == `SC_OFF_STAT);
	assign rd_data = acc & i_avs_read & (i_avs_address == `SC_OFF_DATA);
	assign ctrl_next = serial_core_pkg::ctrl_s'(i_avs_writedata[7:0]);

	always_comb
	begin
		stat_word = 32'h0000_0000;
		stat_word[`SC_ST_TXE] = txe_reg;
		stat_word[`SC_ST_TXDONE] = txdone_reg;
		stat_word[`SC_ST_RXF] = rxf_reg;
		stat_word[`SC_ST_OVR] = ovr_reg;
		stat_word[`SC_ST_NOISE] = noise_reg;
		stat_word[`SC_ST_FRAME] = frame_reg;
		// no parity logic here, so the parity flag never sets
		stat_word[`SC_ST_PARITY] = 1'b0;
		stat_word[`SC_ST_RX9] = rx_buf_reg[8];
		stat_word[`SC_ST_PIN] = o_tx_pin_active;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			resp_reg <= 1'b0;
		else
			resp_reg <= req & ~resp_reg;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			o_avs_readdata <= 32'h0000_0000;
		else if (i_avs_read & ~resp_reg)
		begin
			unique case (i_avs_address)
				`SC_OFF_BAUD: o_avs_readdata <= 32'(baud_reg);
				`SC_OFF_CTRL: o_avs_readdata <= {24'h00_0000, ctrl_reg};
				`SC_OFF_STAT: o_avs_readdata <= stat_word;
				`SC_OFF_DATA: o_avs_readdata <= {24'h00_0000, rx_buf_reg[7:0]};
				default: o_avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			baud_reg <= DIV_W'(`SC_RST_BAUD);
			ctrl_reg <= serial_core_pkg::ctrl_s'(`SC_RST_CTRL);
		end
		else
		begin
			if (wr_baud)
				baud_reg <= i_avs_writedata[DIV_W-1:0];
			if (wr_ctrl)
				ctrl_reg <= ctrl_next;
		end
	end

	// ----------------------------------------------------------------
	// baud generator
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] div_cnt_reg;
	logic tick16;
	logic [3:0] tx_sub_reg;
	logic bit_tick;

	assign tick16 = (baud_reg != '0) && (div_cnt_reg == baud_reg - 1'b1);
	assign bit_tick = tick16 && (tx_sub_reg == `SC_SLOTS);

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst || tick16 || baud_reg == '0)
			div_cnt_reg <= '0;
		else
			div_cnt_reg <= div_cnt_reg + 1'b1;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			tx_sub_reg <= 4'h0;
		else if (tick16)
			tx_sub_reg <= tx_sub_reg + 4'h1;
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	logic pre_pend_reg;
	logic brk_pend_reg;
	logic tx_busy_reg;
	logic [13:0] tx_sh_reg;
	logic [3:0] tx_left_reg;
	logic tx_slot_free;
	logic load_pre;
	logic load_brk;
	logic load_dat;
	logic [3:0] frame_len;

	assign frame_len = ctrl_reg.nine_bit_mode ? `SC_FRAME9 : `SC_FRAME8;
	assign tx_slot_free = bit_tick && (!tx_busy_reg || tx_left_reg == 4'h1);
	assign load_pre = tx_slot_free && pre_pend_reg;
	assign load_brk = tx_slot_free && !pre_pend_reg && brk_pend_reg;
	// data only moves while enabled; queued idle and break still go
	assign load_dat = tx_slot_free && !pre_pend_reg && !brk_pend_reg
		&& ctrl_reg.tx_on && !txe_reg;

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			pre_pend_reg <= 1'b0;
			brk_pend_reg <= 1'b0;
		end
		else
		begin
			if (wr_ctrl && ctrl_next.tx_on && !ctrl_reg.tx_on)
				pre_pend_reg <= 1'b1;
			else if (load_pre)
				pre_pend_reg <= 1'b0;
			if (wr_ctrl && ctrl_next.break_send_request
				&& !ctrl_reg.break_send_request)
				brk_pend_reg <= 1'b1;
			else if (load_brk)
				brk_pend_reg <= ctrl_reg.break_send_request;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			tx_busy_reg <= 1'b0;
			tx_sh_reg <= 14'h3FFF;
			tx_left_reg <= 4'h0;
		end
		else if (load_pre)
		begin
			tx_busy_reg <= 1'b1;
			tx_sh_reg <= 14'h3FFF;
			tx_left_reg <= frame_len;
		end
		else if (load_brk)
		begin
			tx_busy_reg <= 1'b1;
			tx_sh_reg <= 14'h0000;
			tx_left_reg <= ctrl_reg.long_break_select
				? frame_len + `SC_BRK_EXTRA : frame_len;
		end
		else if (load_dat)
		begin
			tx_busy_reg <= 1'b1;
			tx_left_reg <= frame_len;
			if (ctrl_reg.nine_bit_mode)
				tx_sh_reg <= {4'b1111, tx_buf_reg, 1'b0};
			else
				tx_sh_reg <= {5'b1_1111, tx_buf_reg[7:0], 1'b0};
		end
		else if (bit_tick && tx_busy_reg)
		begin
			tx_sh_reg <= {1'b1, tx_sh_reg[13:1]};
			tx_left_reg <= tx_left_reg - 4'h1;
			if (tx_left_reg == 4'h1)
				tx_busy_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			txe_reg <= 1'b1;
			txdone_reg <= 1'b1;
			tx_buf_reg <= 9'h000;
		end
		else
		begin
			// ninth bit taken with the data write
			if (wr_data)
				tx_buf_reg <= {ctrl_reg.tx_ninth_bit, i_avs_writedata[7:0]};
			if (wr_data)
				txe_reg <= 1'b0;
			else if (load_dat)
				txe_reg <= 1'b1;
			// done once the last stop bit leaves
			if (tx_slot_free && tx_busy_reg && !load_pre && !load_brk
				&& !load_dat)
				txdone_reg <= 1'b1;
			else if (wr_data || load_pre || load_brk || pre_pend_reg
				|| brk_pend_reg)
				txdone_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			o_txd <= 1'b1;
			o_tx_pin_active <= 1'b0;
		end
		else
		begin
			o_txd <= (tx_busy_reg ? tx_sh_reg[0] : 1'b1)
				^ ctrl_reg.tx_polarity_invert;
			// pin held while any frame remains
			o_tx_pin_active <= ctrl_reg.tx_on | tx_busy_reg | pre_pend_reg
				| brk_pend_reg;
		end
	end

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	logic rx_s1_reg;
	logic rx_s2_reg;
	logic rx_s3_reg;
	logic rx_lvl_reg;
	logic rx_in;
	logic [2:0] hist_reg;
	logic fall;
	serial_core_pkg::rx_state_e rx_st_reg;
	logic [3:0] slot_reg;
	logic [3:0] rx_bitn_reg;
	logic [2:0] st_smp_reg;
	logic [1:0] mid_reg;
	logic rx_noise_reg;
	logic [8:0] rx_sh_reg;
	logic maj;
	logic done_frame;
	logic stop_zero;
	logic [8:0] rx_word;
	logic [3:0] stop_idx;

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			rx_s3_reg <= 1'b1;
			rx_lvl_reg <= 1'b1;
		end
		else
		begin
			rx_s1_reg <= i_rxd;
			rx_s2_reg <= rx_s1_reg;
			rx_s3_reg <= rx_s2_reg;
			if (rx_s2_reg == rx_s3_reg)
				rx_lvl_reg <= rx_s3_reg;
		end
	end

	assign rx_in = rx_lvl_reg ^ ctrl_reg.rx_polarity_invert;
	assign fall = tick16 && ctrl_reg.rx_on && hist_reg == 3'b111 && !rx_in;
	assign maj = (mid_reg[0] & mid_reg[1]) | (mid_reg[0] & rx_in)
		| (mid_reg[1] & rx_in);
	assign stop_idx = ctrl_reg.nine_bit_mode ? `SC_STOP9 : `SC_STOP8;
	assign done_frame = tick16 && rx_st_reg == serial_core_pkg::RX_BITS
		&& slot_reg == 4'h9 && rx_bitn_reg == stop_idx;
	assign stop_zero = !maj;
	assign rx_word = ctrl_reg.nine_bit_mode ? rx_sh_reg
		: {1'b0, rx_sh_reg[8:1]};

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst || !ctrl_reg.rx_on)
			hist_reg <= 3'b000;
		// preload ones after a non-break framing error
		else if (done_frame && stop_zero && rx_word[7:0] != 8'h00)
			hist_reg <= 3'b111;
		else if (tick16)
			hist_reg <= {hist_reg[1:0], rx_in};
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst || !ctrl_reg.rx_on)
		begin
			rx_st_reg <= serial_core_pkg::RX_IDLE;
			slot_reg <= 4'h0;
			rx_bitn_reg <= 4'h0;
			st_smp_reg <= 3'b000;
			mid_reg <= 2'b00;
			rx_noise_reg <= 1'b0;
			rx_sh_reg <= 9'h000;
		end
		else if (tick16)
		begin
			slot_reg <= slot_reg + 4'h1;
			// each falling edge realigns the slot count
			if (fall)
				slot_reg <= 4'h1;
			unique case (rx_st_reg)
				serial_core_pkg::RX_IDLE:
					if (fall)
					begin
						rx_st_reg <= serial_core_pkg::RX_START;
						rx_noise_reg <= 1'b0;
						rx_bitn_reg <= 4'h0;
					end
				serial_core_pkg::RX_START:
				begin
					// qualify start at slots 2, 4, 6
					if (slot_reg == 4'h2 || slot_reg == 4'h4 || slot_reg == 4'h6)
						st_smp_reg <= {st_smp_reg[1:0], rx_in};
					if (slot_reg == 4'h6 && ((st_smp_reg[1] & st_smp_reg[0])
						| (st_smp_reg[1] & rx_in) | (st_smp_reg[0] & rx_in)))
						rx_st_reg <= serial_core_pkg::RX_IDLE;
					// start forced zero, a one at slots 2, 4, 6, 7 or 8 is noise
					if ((slot_reg >= 4'h2 && slot_reg <= 4'h9 && slot_reg[0] == 1'b0
						&& slot_reg != 4'h8) || slot_reg == 4'h7 || slot_reg == 4'h8)
						if (rx_in && slot_reg != 4'h3 && slot_reg != 4'h5)
							rx_noise_reg <= 1'b1;
					if (slot_reg == 4'hF)
					begin
						rx_st_reg <= serial_core_pkg::RX_BITS;
						rx_bitn_reg <= 4'h1;
					end
				end
				serial_core_pkg::RX_BITS:
				begin
					if (slot_reg == 4'h7 || slot_reg == 4'h8)
						mid_reg <= {mid_reg[0], rx_in};
					if (slot_reg == 4'h9)
					begin
						if (mid_reg[0] != maj || mid_reg[1] != maj || rx_in != maj)
							rx_noise_reg <= 1'b1;
						if (rx_bitn_reg == stop_idx)
							rx_st_reg <= serial_core_pkg::RX_IDLE;
						else
							rx_sh_reg <= {maj, rx_sh_reg[8:1]};
					end
					if (slot_reg == 4'hF && !fall)
						rx_bitn_reg <= rx_bitn_reg + 4'h1;
				end
				default: rx_st_reg <= serial_core_pkg::RX_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// receive buffer and flags
	// ----------------------------------------------------------------
	logic rx_take;
	logic rx_lose;

	assign rx_take = done_frame && !frame_reg && !rxf_reg;
	assign rx_lose = done_frame && !frame_reg && rxf_reg;

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			rx_buf_reg <= 9'h000;
			rxf_reg <= 1'b0;
			ovr_reg <= 1'b0;
			noise_reg <= 1'b0;
			frame_reg <= 1'b0;
			arm_reg <= 1'b0;
		end
		else
		begin
			if (rd_stat)
				arm_reg <= rxf_reg | ovr_reg;
			else if (rd_data)
				arm_reg <= 1'b0;
			// status read then data read clears
			if (rd_data && arm_reg)
			begin
				rxf_reg <= 1'b0;
				ovr_reg <= 1'b0;
				noise_reg <= 1'b0;
				frame_reg <= 1'b0;
			end
			if (rx_take)
			begin
				rx_buf_reg <= rx_word;
				rxf_reg <= 1'b1;
				noise_reg <= rx_noise_reg | (mid_reg[0] != maj)
					| (mid_reg[1] != maj) | (rx_in != maj);
				frame_reg <= stop_zero;
			end
			if (rx_lose)
				ovr_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_idle_high;
		@(posedge i_clk) disable iff (i_sys_rst)
		$past(!tx_busy_reg) && $past(!i_sys_rst) |->
			o_txd == !$past(ctrl_reg.tx_polarity_invert);
	endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("idle output level wrong");

	property p_pre_queued;
		@(posedge i_clk) disable iff (i_sys_rst)
		wr_ctrl && ctrl_next.tx_on && !ctrl_reg.tx_on |=> pre_pend_reg;
	endproperty
	a_pre_queued: assert property (p_pre_queued)
		else $error("enable did not queue idle frame");

	property p_txe_on_load;
		@(posedge i_clk) disable iff (i_sys_rst)
		load_dat && !wr_data |=> txe_reg && tx_busy_reg;
	endproperty
	a_txe_on_load: assert property (p_txe_on_load)
		else $error("empty flag not set on load");

	property p_frame_len;
		@(posedge i_clk) disable iff (i_sys_rst)
		load_dat |=> tx_left_reg == (ctrl_reg.nine_bit_mode ? 4'hB : 4'hA);
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("data frame length wrong");

	property p_brk_len;
		@(posedge i_clk) disable iff (i_sys_rst)
		load_brk && ctrl_reg.long_break_select && !ctrl_reg.nine_bit_mode
			|=> tx_left_reg == 4'hD && tx_sh_reg == 14'h0000;
	endproperty
	a_brk_len: assert property (p_brk_len)
		else $error("long break length wrong");

	property p_pin_kept;
		@(posedge i_clk) disable iff (i_sys_rst)
		tx_busy_reg && !ctrl_reg.tx_on |=> o_tx_pin_active;
	endproperty
	a_pin_kept: assert property (p_pin_kept)
		else $error("pin released while shifting");

	property p_overrun;
		@(posedge i_clk) disable iff (i_sys_rst)
		rx_lose |=> ovr_reg && $stable(rx_buf_reg);
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun not flagged or buffer changed");

	property p_fe_blocks;
		@(posedge i_clk) disable iff (i_sys_rst)
		frame_reg && !(rd_data && arm_reg) |=> $stable(rx_buf_reg);
	endproperty
	a_fe_blocks: assert property (p_fe_blocks)
		else $error("character taken while framing flag set");

	property p_rx_off;
		@(posedge i_clk) disable iff (i_sys_rst)
		!ctrl_reg.rx_on |=> rx_st_reg == serial_core_pkg::RX_IDLE;
	endproperty
	a_rx_off: assert property (p_rx_off)
		else $error("receiver active while disabled");

	property p_flags_with_full;
		@(posedge i_clk) disable iff (i_sys_rst)
		$rose(frame_reg) || $rose(noise_reg) |-> $rose(rxf_reg);
	endproperty
	a_flags_with_full: assert property (p_flags_with_full)
		else $error("error flag set apart from buffer-full");

	property p_bus_answer;
		@(posedge i_clk) disable iff (i_sys_rst)
		req && o_avs_waitrequest |=> !o_avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("bus answer later than one wait cycle");

	c_rx_char: cover property (@(posedge i_clk) disable iff (i_sys_rst)
		rx_take);
	c_overrun: cover property (@(posedge i_clk) disable iff (i_sys_rst)
		rx_lose);
	c_break_tx: cover property (@(posedge i_clk) disable iff (i_sys_rst)
		load_brk);
	c_tx_done: cover property (@(posedge i_clk) disable iff (i_sys_rst)
		$rose(txdone_reg));
endmodule : async_serial_tx_rx_core
`default_nettype wire

// File: verif/serial_peer.sv
// remote serial device model that drives and watches the line
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
	parameter int BIT = 16
) (
	input wire logic i_clk,
	input wire logic i_line,
	output logic o_line
);
	// ----------------------------------------
	// line driver and line watchers
	// ----------------------------------------
	// idle line is pulled high between frames
	initial o_line = 1'b1;
	// start, data lsb first, stop
	// glitch and bad stop only when the bench asks for them
	task automatic send(input logic [8:0] d, input int nb, input logic stp,
		input int gl);
		logic v;
		for (int i = 0; i < nb + 4; i++)
		begin
			for (int c = 0; c < BIT; c++)
			begin
				v = (i == 0) ? 1'b0 : (i <= nb) ? d[i - 1] :
					(i == nb + 1) ? stp : 1'b1;
				@(posedge i_clk);
				// two clocks wide, or the input filter swallows it
				o_line <= v ^ (i == gl
					&& (c == BIT / 2 + 1 || c == BIT / 2 + 2));
			end
		end
	endtask : send
	// frame capture mid-bit
	// ends at mid stop so a following start edge is not missed
	task automatic grab(input int nb, output logic [10:0] f, output int n);
		n = 0;
		f = '0;
		while (i_line !== 1'b0 && n < 5000)
		begin
			@(posedge i_clk);
			n++;
		end
		repeat (BIT / 2) @(posedge i_clk);
		for (int i = 0; i < nb + 2; i++)
		begin
			f[i] = i_line;
			if (i < nb + 1)
				repeat (BIT) @(posedge i_clk);
		end
	endtask : grab
	task automatic low_len(output int n);
		int k;
		k = 0;
		n = 0;
		while (i_line !== 1'b0 && k < 5000)
		begin
			@(posedge i_clk);
			k++;
		end
		while (i_line === 1'b0 && n < 5000)
		begin
			@(posedge i_clk);
			n++;
		end
	endtask : low_len
endmodule : serial_peer
`default_nettype wire

// File: verif/async_serial_tx_rx_core_tb.sv
// self-checking bench for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
module async_serial_tx_rx_core_tb;
	logic clk;
	logic rst;
	logic [3:0] adr;
	logic rd_en;
	logic wr_en;
	logic [31:0] wdat;
	logic [31:0] rdata;
	logic wait_req;
	logic rxd;
	logic txd;
	logic pin_act;
	int bad_count;
	int check_count;
	int n;
	// data frame first: its end aligns later break requests to a bit tick
	logic [3:0] ta1 [5] = '{4'hC, 4'h4, 4'h4, 4'h4, 4'h4};
	logic [7:0] td1 [5] = '{8'h00, 8'h07, 8'h0F, 8'h17, 8'h1F};
	logic [3:0] ta2 [5] = '{4'h0, 4'h4, 4'h4, 4'h4, 4'h4};
	logic [7:0] td2 [5] = '{8'h01, 8'h03, 8'h0B, 8'h13, 8'h1B};
	int tl [5] = '{144, 160, 208, 176, 224};
	async_serial_tx_rx_core i_async_serial_tx_rx_core (
		.i_clk(clk), .i_sys_rst(rst), .i_avs_address(adr),
		.i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdat),
		.i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wait_req), .i_rxd(rxd), .o_txd(txd),
		.o_tx_pin_active(pin_act)
	);
	serial_peer i_serial_peer (.i_clk(clk), .i_line(txd), .o_line(rxd));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out
	task automatic fail_out;
		bad_count++;
		$display("BAD %0t wait ran out", $time);
		close_out();
	endtask : fail_out
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// request held until waitrequest is seen low at a rising edge
	task automatic av(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int k;
		@(posedge clk);
		adr <= a;
		wdat <= d;
		wr_en <= w;
		rd_en <= ~w;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end while (wait_req !== 1'b0 && k < 100);
		q = rdata;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		if (k >= 100)
			fail_out();
	endtask : av
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		av(1'b1, a, d, q);
	endtask : wr
	// only the low byte is compared; the pin flag in status bit 8 is masked off
	task automatic rcmp(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		av(1'b0, a, 32'h0000_0000, q);
		cmp(q & 32'h0000_00FF, exp);
	endtask : rcmp
	// the transmit buffer is one deep: poll the empty flag before refilling
	task automatic txe_wait;
		logic [31:0] q;
		int k;
		k = 0;
		q = 32'h0000_0000;
		while (q[0] !== 1'b1 && k < 400)
		begin
			av(1'b0, 4'h8, 32'h0000_0000, q);
			k++;
		end
		if (k >= 400)
			fail_out();
	endtask : txe_wait
	task automatic tx_chk(input int nb, input logic [10:0] exp, output int k);
		logic [10:0] f;
		i_serial_peer.grab(nb, f, k);
		if (k >= 5000)
			fail_out();
		cmp({21'h0, f}, {21'h0, exp});
	endtask : tx_chk
	task automatic rx_chk(input logic [8:0] d, input int nb, input logic stp,
		input int gl, input logic [31:0] st, input logic [31:0] dat);
		i_serial_peer.send(d, nb, stp, gl);
		rcmp(4'h8, st);
		rcmp(4'hC, dat);
	endtask : rx_chk
	// ----------------------------------------
	// clock and main sequence
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		rst = 1'b1;
		adr = 4'h0;
		rd_en = 1'b0;
		wr_en = 1'b0;
		wdat = 32'h0000_0000;
		bad_count = 0;
		check_count = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rcmp(4'h8, 32'h0000_0003);
		rcmp(4'h0, 32'h0000_0000);
		rcmp(4'h2, 32'h0000_0000);
		cmp({31'h0, txd}, 32'h0000_0001);
		cmp({31'h0, pin_act}, 32'h0000_0000);
		wr(4'h4, 32'h0000_0020);
		repeat (3) @(posedge clk);
		cmp({31'h0, txd}, 32'h0000_0000);
		wr(4'h4, 32'h0000_0000);
		wr(4'h0, 32'h0000_0001);
		wr(4'h4, 32'h0000_0003);
		wr(4'hC, 32'h0000_00A5);
		tx_chk(8, {2'b01, 8'hA5, 1'b0}, n);
		cmp({31'h0, n >= 140}, 32'h0000_0001);
		repeat (16) @(posedge clk);
		rcmp(4'h8, 32'h0000_0003);
		fork
			begin
				tx_chk(8, {2'b01, 8'h11, 1'b0}, n);
				tx_chk(8, {2'b01, 8'h22, 1'b0}, n);
			end
			begin
				wr(4'hC, 32'h0000_0011);
				txe_wait();
				wr(4'hC, 32'h0000_0022);
			end
		join
		wr(4'h4, 32'h0000_0093);
		fork
			tx_chk(9, {2'b11, 8'h3C, 1'b0}, n);
			wr(4'hC, 32'h0000_003C);
		join
		for (int k = 0; k < 5; k++)
		begin
			fork
				i_serial_peer.low_len(n);
				begin
					wr(ta1[k], {24'h0, td1[k]});
					wr(ta2[k], {24'h0, td2[k]});
				end
			join
			cmp(32'(n), 32'(tl[k]));
		end
		fork
			// still nine-bit mode at load: ninth bit zero, then stop
			tx_chk(9, {2'b10, 8'h5A, 1'b0}, n);
			begin
				wr(4'hC, 32'h0000_005A);
				repeat (40) @(posedge clk);
				wr(4'h4, 32'h0000_0002);
			end
		join
		repeat (16) @(posedge clk);
		rcmp(4'h8, 32'h0000_0003);
		cmp({31'h0, pin_act}, 32'h0000_0000);
		wr(4'h4, 32'h0000_0003);
		rx_chk(9'h03C, 8, 1'b1, -1, 32'h0000_0007, 32'h0000_003C);
		rcmp(4'h8, 32'h0000_0003);
		i_serial_peer.send(9'h011, 8, 1'b1, -1);
		rx_chk(9'h022, 8, 1'b1, -1, 32'h0000_000F, 32'h0000_0011);
		i_serial_peer.send(9'h081, 8, 1'b0, -1);
		// a bad stop restarts the edge search at once; let that frame run out
		repeat (160) @(posedge clk);
		rx_chk(9'h044, 8, 1'b1, -1, 32'h0000_0027, 32'h0000_0081);
		rx_chk(9'h000, 8, 1'b0, -1, 32'h0000_0027, 32'h0000_0000);
		rx_chk(9'h055, 8, 1'b1, 2, 32'h0000_0017, 32'h0000_0055);
		wr(4'h4, 32'h0000_0001);
		i_serial_peer.send(9'h066, 8, 1'b1, -1);
		rcmp(4'h8, 32'h0000_0003);
		wr(4'h4, 32'h0000_0013);
		rx_chk(9'h1A5, 9, 1'b1, -1, 32'h0000_0087, 32'h0000_00A5);
		close_out();
	end
endmodule : async_serial_tx_rx_core_tb
`default_nettype wire
